//--- inc/mbf_pkg.sv
// Constants, types and reset values shared by the frame filter and its helpers.
package mbf_pkg;

  // ----------------------------------------------------------------------
  // Character and frame sizes
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int LEN_W = 9;
  localparam int MAX_FRAME = 256;
  localparam logic [LEN_W-1:0] LEN_MAX = 9'h100;
  localparam logic [LEN_W-1:0] LEN_MIN = 9'h004;
  localparam logic [LEN_W-1:0] LEN_FIXED = 9'h008;
  localparam logic [LEN_W-1:0] LEN_WRITE_HDR = 9'h009;
  localparam logic [LEN_W-1:0] LEN_CRC_TAIL = 9'h003;

  // ----------------------------------------------------------------------
  // Timing counts, in bit times of the serial link
  // ----------------------------------------------------------------------
  localparam logic [5:0] GAP_MAX_BITS = 6'h18;
  localparam logic [5:0] SILENT_BITS = 6'h27;
  localparam logic [5:0] TEST_TIMEOUT_BITS = 6'h30;

  // ----------------------------------------------------------------------
  // Check sequence
  // ----------------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // ----------------------------------------------------------------------
  // Addresses, function codes, settings
  // ----------------------------------------------------------------------
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  localparam logic [7:0] FN_READ_REGS = 8'h03;
  localparam logic [7:0] FN_LOOPBACK = 8'h08;
  localparam logic [7:0] FN_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
  localparam logic [7:0] SELF_TEST_SELECT = 8'h43;
  localparam logic [7:0] TEST_SEED = 8'hA5;

  // ----------------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------------
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------------
  // State and reason encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SYNC = 3'h0,
    ST_IDLE = 3'h1,
    ST_RECV = 3'h3,
    ST_CHECK = 3'h2,
    ST_EMIT = 3'h6,
    ST_DROP = 3'h4
  } mbf_state_type;

  typedef enum logic [2:0] {
    DR_NONE = 3'h0,
    DR_LINE = 3'h1,
    DR_CRC = 3'h2,
    DR_ADDR = 3'h3,
    DR_GAP = 3'h4,
    DR_LEN = 3'h5,
    DR_BCAST = 3'h6,
    DR_BUSY = 3'h7
  } mbf_reason_type;

  typedef struct packed {
    mbf_state_type state;
    logic [5:0] gap;
    logic [LEN_W-1:0] len;
    logic [15:0] crc;
    logic [LEN_W-1:0] emit_idx;
    logic bcast;
    logic lost;
    logic drop_pulse;
    mbf_reason_type drop_reason;
    logic exc_valid;
    logic [7:0] exc_code;
    logic [7:0] exc_func;
    logic st_mode;
    logic st_wait;
    logic [7:0] st_pat;
    logic [5:0] st_timer;
    logic st_pass;
    logic st_fault;
    logic tx_valid;
    logic [7:0] tx_data;
  } mbf_filter_state_type;

  localparam mbf_filter_state_type FILTER_RESET = '{
    state: ST_SYNC, drop_reason: DR_NONE, crc: CRC_INIT, default: '0
  };

endpackage

//--- hw/mbf_crc16.sv
// One-byte step of the reflected 16-bit frame check sequence.
`timescale 1ns/1ps
`default_nettype none
module mbf_crc16
  import mbf_pkg::*;
(
  // Running value and new byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  // Updated value
  output logic [15:0] crc_out
);

  // ----------------------------------------------------------------------
  // Bitwise update, least significant bit first
  // ----------------------------------------------------------------------

  // Eight shift steps, purely combinational.
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end

endmodule
`default_nettype wire

//--- hw/mbf_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module mbf_fifo
  import mbf_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0] wr;
    logic [PW:0] rd;
  } mbf_fifo_state_type;

  mbf_fifo_state_type r;
  mbf_fifo_state_type n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // ----------------------------------------------------------------------
  // Flags and pointers
  // ----------------------------------------------------------------------

  // Full when pointers differ only in the wrap bit.
  always_comb begin
    in_ready = !((r.wr[PW] != r.rd[PW]) && (r.wr[PW-1:0] == r.rd[PW-1:0]));
    out_valid = (r.wr != r.rd);
    out_data = mem[r.rd[PW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    n = r;
    if (push) begin
      n.wr = r.wr + 1'b1;
    end
    if (pop) begin
      n.rd = r.rd + 1'b1;
    end
  end

  // Pointers and storage freeze while the enable is low.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
      if (push) begin
        mem[r.wr[PW-1:0]] <= in_data;
      end
    end
  end

endmodule
`default_nettype wire

//--- hw/mbf_frame_filter.sv
// Receive-side acceptance filter for serial slave command frames.
//
// Behaviour
// - A frame with an overrun, framing, parity or check-sequence error is discarded with no reply.
// - A frame whose address is neither broadcast nor the node address setting is ignored with no reply.
// - A frame is dropped when the idle gap between two characters exceeds 24 bit times.
// - A frame whose data length does not suit its function is discarded entirely.
// - A broadcast frame (address 00H) has its write carried out but is marked so that no reply is sent.
// - Setting the input six function select to 67 places the serial interface in loopback self-test mode.
// - In self-test mode a pass flag shows while looped bytes return intact, and a fault flag once a test fails.
// - A frame for this node with a function other than 03H, 08H or 10H raises exception code 01H.
`timescale 1ns/1ps
`default_nettype none
module mbf_frame_filter
  import mbf_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Settings
  input wire logic [7:0] node_address_setting,
  input wire logic [7:0] input_six_function_select,
  // Character receiver
  input wire logic bit_tick,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_overrun_err,
  input wire logic rx_framing_err,
  input wire logic rx_parity_err,
  // Accepted frame stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  output logic out_broadcast,
  input wire logic out_ready,
  // Discard and exception events
  output logic drop_pulse,
  output logic [2:0] drop_reason,
  output logic exc_valid,
  output logic [7:0] exc_code,
  output logic [7:0] exc_func,
  // Self-test
  output logic self_test_mode,
  output logic test_pass,
  output logic test_comm_error,
  output logic test_tx_valid,
  output logic [7:0] test_tx_data,
  input wire logic test_tx_ready
);

  mbf_filter_state_type r;
  mbf_filter_state_type n;
  logic [7:0] frame_mem [MAX_FRAME];
  logic wr_en;
  logic line_err;
  logic [15:0] crc_seed;
  logic [15:0] crc_step;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FIFO_WIDTH-1:0] fifo_in_data;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic drop_now;
  mbf_reason_type drop_why;
  logic [7:0] addr;
  logic [7:0] func;
  logic [15:0] qty;
  logic [7:0] byte_cnt;
  logic is_bcast;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Only the three supported operations are known.
  function automatic logic known_function(input logic [7:0] fn);
    return (fn == FN_READ_REGS) || (fn == FN_LOOPBACK) || (fn == FN_WRITE_MULTI);
  endfunction

  // Length check per operation; a write must carry exactly twice its word count in bytes.
  function automatic logic length_valid(input logic [7:0] fn, input logic [LEN_W-1:0] len,
                                        input logic [15:0] q, input logic [7:0] bc);
    logic ok;
    ok = 1'b0;
    if (fn == FN_WRITE_MULTI) begin
      ok = (len >= LEN_WRITE_HDR) && (q != 16'h0000) && ({8'h00, bc} == {q[14:0], 1'b0}) &&
           (q[15] == 1'b0) && (len == LEN_WRITE_HDR + {1'b0, bc});
    end else begin
      ok = (len == LEN_FIXED);
    end
    return ok;
  endfunction

  // ----------------------------------------------------------------------
  // Check sequence and output buffer
  // ----------------------------------------------------------------------

  assign line_err = rx_overrun_err || rx_framing_err || rx_parity_err;
  assign crc_seed = (r.state == ST_IDLE) ? CRC_INIT : r.crc;

  mbf_crc16 u_crc (
    .crc_in(crc_seed),
    .data(rx_data),
    .crc_out(crc_step)
  );

  // Back-pressure from the consumer stalls the emission state below.
  mbf_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(out_valid),
    .out_data(fifo_out_data),
    .out_ready(out_ready)
  );

  assign out_data = fifo_out_data[7:0];
  assign out_last = fifo_out_data[8];
  assign out_broadcast = fifo_out_data[9];

  // ----------------------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------------------

  // Fields beyond the received length hold stale bytes; the checks guard every use.
  always_comb begin
    addr = frame_mem[0];
    func = frame_mem[1];
    qty = {frame_mem[4], frame_mem[5]};
    byte_cnt = frame_mem[6];
    is_bcast = (addr == BROADCAST_ADDR);
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // One pass fills the whole next state; the frame path rests while self-test runs.
  always_comb begin
    n = r;
    wr_en = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    drop_now = 1'b0;
    drop_why = DR_NONE;
    n.drop_pulse = 1'b0;
    n.exc_valid = 1'b0;

    // Idle time since the last character, saturating at the silent interval.
    if (rx_valid) begin
      n.gap = 6'h00;
    end else if (bit_tick && (r.gap != SILENT_BITS)) begin
      n.gap = r.gap + 6'h01;
    end

    n.st_mode = (input_six_function_select == SELF_TEST_SELECT);

    if (!r.st_mode) begin
      unique case (r.state)
        ST_SYNC, ST_DROP: begin
          // A character inside the silence restarts the wait.
          if (!rx_valid && (r.gap == SILENT_BITS)) begin
            n.state = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (rx_valid) begin
            if (line_err) begin
              drop_now = 1'b1;
              drop_why = DR_LINE;
            end else begin
              wr_en = 1'b1;
              n.crc = crc_step;
              n.len = 9'h001;
              n.state = ST_RECV;
            end
          end
        end
        ST_RECV: begin
          if (rx_valid) begin
            if (line_err) begin
              drop_now = 1'b1;
              drop_why = DR_LINE;
            end else if (r.gap > GAP_MAX_BITS) begin
              drop_now = 1'b1;
              drop_why = DR_GAP;
            end else if (r.len == LEN_MAX) begin
              drop_now = 1'b1;
              drop_why = DR_LEN;
            end else begin
              wr_en = 1'b1;
              n.crc = crc_step;
              n.len = r.len + 9'h001;
            end
          end else if (r.gap == SILENT_BITS) begin
            n.state = ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (rx_valid) begin
            n.lost = 1'b1;
          end
          if (r.len < LEN_MIN) begin
            drop_now = 1'b1;
            drop_why = DR_LEN;
          end else if (r.crc != CRC_GOOD) begin
            drop_now = 1'b1;
            drop_why = DR_CRC;
          end else if (!is_bcast && (addr != node_address_setting)) begin
            drop_now = 1'b1;
            drop_why = DR_ADDR;
          end else if (!known_function(func)) begin
            if (is_bcast) begin
              drop_now = 1'b1;
              drop_why = DR_BCAST;
            end else begin
              n.exc_valid = 1'b1;
              n.exc_code = EXC_BAD_FUNCTION;
              n.exc_func = func;
              n.state = ST_IDLE;
            end
          end else if (!length_valid(func, r.len, qty, byte_cnt)) begin
            drop_now = 1'b1;
            drop_why = DR_LEN;
          end else if (is_bcast && (func != FN_WRITE_MULTI)) begin
            drop_now = 1'b1;
            drop_why = DR_BCAST;
          end else begin
            n.bcast = is_bcast;
            n.emit_idx = 9'h000;
            n.state = ST_EMIT;
          end
          if (!drop_now && (n.state == ST_IDLE) && (r.lost || rx_valid)) begin
            drop_now = 1'b1;
            drop_why = DR_BUSY;
          end
        end
        ST_EMIT: begin
          // The two check bytes stay behind; the consumer sees address to last data byte.
          if (rx_valid) begin
            n.lost = 1'b1;
          end
          fifo_in_valid = 1'b1;
          fifo_in_data = {r.bcast, (r.emit_idx == r.len - LEN_CRC_TAIL), frame_mem[r.emit_idx[7:0]]};
          if (fifo_in_ready) begin
            n.emit_idx = r.emit_idx + 9'h001;
            if (r.emit_idx == r.len - LEN_CRC_TAIL) begin
              if (r.lost || rx_valid) begin
                drop_now = 1'b1;
                drop_why = DR_BUSY;
              end else begin
                n.state = ST_IDLE;
              end
            end
          end
        end
        default: begin
          n.state = ST_SYNC;
        end
      endcase
    end else begin
      n.state = ST_SYNC;
      n.lost = 1'b0;
    end

    // A discard reports once and resynchronises on the next silence.
    if (drop_now) begin
      n.state = ST_DROP;
      n.lost = 1'b0;
      n.drop_pulse = 1'b1;
      n.exc_valid = 1'b0;
      n.drop_reason = drop_why;
    end

    // Self-test: send a counting pattern, expect it back intact within the timeout.
    if (n.st_mode && !r.st_mode) begin
      n.st_pat = TEST_SEED;
      n.st_wait = 1'b0;
      n.st_timer = 6'h00;
      n.st_pass = 1'b0;
      n.st_fault = 1'b0;
      n.tx_valid = 1'b0;
    end else if (!n.st_mode) begin
      n.st_wait = 1'b0;
      n.st_pass = 1'b0;
      n.st_fault = 1'b0;
      n.tx_valid = 1'b0;
    end else if (!r.st_wait) begin
      if (r.tx_valid && test_tx_ready) begin
        n.tx_valid = 1'b0;
        n.st_wait = 1'b1;
        n.st_timer = 6'h00;
      end else if (!r.tx_valid) begin
        n.tx_valid = 1'b1;
        n.tx_data = r.st_pat;
      end
    end else if (rx_valid) begin
      n.st_wait = 1'b0;
      n.st_pat = r.st_pat + 8'h01;
      if (line_err || (rx_data != r.st_pat)) begin
        n.st_fault = 1'b1;
        n.st_pass = 1'b0;
      end else if (!r.st_fault) begin
        n.st_pass = 1'b1;
      end
    end else if (bit_tick) begin
      n.st_timer = r.st_timer + 6'h01;
      if (r.st_timer == TEST_TIMEOUT_BITS) begin
        n.st_wait = 1'b0;
        n.st_fault = 1'b1;
        n.st_pass = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Whole state freezes while the enable is low.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= FILTER_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  // Frame store written at the running length; a frame start lands at zero.
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      frame_mem[(r.state == ST_IDLE) ? 8'h00 : r.len[7:0]] <= rx_data;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign drop_pulse = r.drop_pulse;
  assign drop_reason = r.drop_reason;
  assign exc_valid = r.exc_valid;
  assign exc_code = r.exc_code;
  assign exc_func = r.exc_func;
  assign self_test_mode = r.st_mode;
  assign test_pass = r.st_pass;
  assign test_comm_error = r.st_fault;
  assign test_tx_valid = r.tx_valid;
  assign test_tx_data = r.tx_data;

endmodule
`default_nettype wire

//--- bench/mbf_filter_properties.sv
// Port-level assertions and covers for the frame filter.
`timescale 1ns/1ps
`default_nettype none
module mbf_filter_checker
  import mbf_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Watched ports
  input wire logic [7:0] input_six_function_select,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready,
  input wire logic drop_pulse,
  input wire logic [2:0] drop_reason,
  input wire logic exc_valid,
  input wire logic [7:0] exc_code,
  input wire logic self_test_mode,
  input wire logic test_pass,
  input wire logic test_comm_error,
  input wire logic test_tx_valid,
  input wire logic [7:0] test_tx_data,
  input wire logic test_tx_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic sel_on;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // Decoded once for the mode checks.
  assign sel_on = input_six_function_select == SELF_TEST_SELECT;
  drop_once_a: assert property (drop_pulse |-> drop_reason != 3'h0 ##1 !drop_pulse)
    else $error("bad drop pulse");
  exc_once_a: assert property (exc_valid |-> exc_code == EXC_BAD_FUNCTION ##1 !exc_valid)
    else $error("bad exception pulse");
  one_outcome_a: assert property (!(drop_pulse && exc_valid))
    else $error("dropped and answered");
  mode_on_a: assert property (ce && sel_on |=> self_test_mode)
    else $error("mode not entered");
  mode_off_a: assert property (ce && !sel_on |=> !self_test_mode)
    else $error("mode without setting");
  flag_excl_a: assert property (!(test_pass && test_comm_error))
    else $error("pass with error");
  idle_flags_a: assert property (!self_test_mode |-> !test_pass && !test_comm_error && !test_tx_valid)
    else $error("test output outside mode");
  fault_keep_a: assert property (test_comm_error && ce && sel_on |=> test_comm_error)
    else $error("error not sticky");
  tx_hold_a: assert property (test_tx_valid && !test_tx_ready && ce && sel_on
                              |=> test_tx_valid && $stable(test_tx_data))
    else $error("test byte not held");
  stream_hold_a: assert property (ce && out_valid && !out_ready
                                  |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled head word changed");
  gap_cov: cover property (drop_pulse && drop_reason == 3'h4);
  exc_cov: cover property (exc_valid);
  last_cov: cover property (out_valid && out_ready && out_last);
  pass_cov: cover property (test_pass);
endmodule

bind mbf_frame_filter mbf_filter_checker u_mbf_filter_checker (.clk, .rstn, .ce,
  .input_six_function_select, .out_valid, .out_data, .out_last, .out_ready, .drop_pulse,
  .drop_reason, .exc_valid, .exc_code, .self_test_mode, .test_pass, .test_comm_error,
  .test_tx_valid, .test_tx_data, .test_tx_ready);
`default_nettype wire

//--- bench/mbf_master_model.sv
// Bus master and self-test jumper model facing the frame filter.
`timescale 1ns/1ps
`default_nettype none
module mbf_master_model
  import mbf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Character receiver side
  output logic bit_tick,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_overrun_err,
  output logic rx_framing_err,
  output logic rx_parity_err,
  // Self-test loop
  input wire logic test_tx_valid,
  input wire logic [7:0] test_tx_data,
  output logic test_tx_ready,
  input wire logic [7:0] loop_flip
);
  logic [1:0] ph = 2'h0;
  logic [7:0] lb;

  // --------------------------------------------------------------
  // Bit timing and characters
  // --------------------------------------------------------------
  // A bit time is four clocks to keep frames short; ready is slow half the time.
  initial begin
    {rx_valid, rx_overrun_err, rx_framing_err, rx_parity_err} = 4'h0;
    rx_data = 8'hFF;
  end
  always @(negedge clk) begin
    ph <= ph + 2'h1;
    bit_tick <= ph == 2'h3;
    test_tx_ready <= ph[1];
  end
  task automatic wait_ticks(input int n);
    repeat (n * 4) @(negedge clk);
  endtask
  // The data line shows the inverse value between characters, never stale data.
  task automatic send_char(input logic [7:0] d, input logic [2:0] e);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = d;
    {rx_overrun_err, rx_framing_err, rx_parity_err} = e;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~d;
    {rx_overrun_err, rx_framing_err, rx_parity_err} = 3'h0;
  endtask
  // Sends n bytes of v plus check bytes; char gi follows a 30 bit gap, char 2 carries e.
  task automatic send_frame(input logic [127:0] v, input int n, input int gi,
                            input logic [15:0] cf, input logic [2:0] e);
    logic [15:0] c;
    logic [7:0] fb [0:17];
    c = CRC_INIT;
    for (int k = 0; k < n; k++) begin
      fb[k] = v[8 * (n - 1 - k) +: 8];
      c = c ^ {8'h00, fb[k]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = c ^ cf;
    fb[n] = c[7:0];
    fb[n + 1] = c[15:8];
    for (int k = 0; k < n + 2; k++) begin
      wait_ticks(k == gi ? 30 : 10);
      send_char(fb[k], k == 2 ? e : 3'h0);
    end
    wait_ticks(45);
  endtask
  // The jumpers return each taken test byte one character time later.
  always @(posedge clk) begin
    if (test_tx_valid && test_tx_ready) begin
      lb = test_tx_data ^ loop_flip;
      wait_ticks(10);
      send_char(lb, 3'h0);
    end
  end
endmodule
`default_nettype wire

//--- bench/tb_mbf_frame_filter.sv
// Self-checking bench for the serial frame filter.
`timescale 1ns/1ps
`default_nettype none
module tb_mbf_frame_filter
  import mbf_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic out_ready = 1'b1;
  logic ce = 1'b1;
  logic [7:0] sel = 8'h00;
  logic [7:0] flip = 8'h00;
  logic bit_tick, rx_valid, rx_overrun_err, rx_framing_err, rx_parity_err;
  logic out_valid, out_last, out_broadcast, drop_pulse, exc_valid;
  logic self_test_mode, test_pass, test_comm_error, test_tx_valid, test_tx_ready;
  logic [7:0] rx_data, out_data, exc_code, exc_func, test_tx_data;
  logic [2:0] drop_reason;
  logic [9:0] wq [$];
  int fail_count = 0;
  int num_checks = 0;
  int n_drop = 0, n_exc = 0, cyc = 0;

  mbf_frame_filter u_mbf_frame_filter (.clk, .rstn, .ce, .node_address_setting(8'h01),
    .input_six_function_select(sel), .bit_tick, .rx_valid, .rx_data, .rx_overrun_err,
    .rx_framing_err, .rx_parity_err, .out_valid, .out_data, .out_last, .out_broadcast,
    .out_ready, .drop_pulse, .drop_reason, .exc_valid, .exc_code, .exc_func, .self_test_mode,
    .test_pass, .test_comm_error, .test_tx_valid, .test_tx_data, .test_tx_ready);
  mbf_master_model u_mbf_master_model (.clk, .bit_tick, .rx_valid, .rx_data, .rx_overrun_err,
    .rx_framing_err, .rx_parity_err, .test_tx_valid, .test_tx_data, .test_tx_ready,
    .loop_flip(flip));

  // --------------------------------------------------------------
  // Clock, monitors and helpers
  // --------------------------------------------------------------
  // Pulses last one cycle, so they are counted at every edge.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready && ce) wq.push_back({out_broadcast, out_last, out_data});
    if (drop_pulse === 1'b1) n_drop++;
    if (exc_valid === 1'b1) n_exc++;
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("ERROR cycles expected <60000 seen 60000");
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic frame(input logic [127:0] v, input int n, input int gi = 99,
                       input logic [15:0] cf = 16'h0000, input logic [2:0] e = 3'h0);
    wq.delete();
    n_drop = 0;
    n_exc = 0;
    u_mbf_master_model.send_frame(v, n, gi, cf, e);
  endtask
  task automatic dropped(input logic [2:0] r);
    chk("drop_count", 16'h1, n_drop);
    chk("drop_reason", {13'h0, r}, drop_reason);
    chk("words", 16'h0, wq.size());
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // A stalled read, then a low enable, must keep every word in the buffer.
  task automatic t_good();
    out_ready = 1'b0;
    frame(128'h010300100002, 6);
    ce = 1'b0;
    out_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk("stall_valid", 16'h1, out_valid);
    chk("stall_words", 16'h0, wq.size());
    ce = 1'b1;
    repeat (20) @(negedge clk);
    chk("drops", 16'h0, n_drop);
    chk("words", 16'h6, wq.size());
    for (int k = 0; k < 6; k++) begin
      chk("word", {7'h00, k == 5, 8'(48'h010300100002 >> (8 * (5 - k)))}, wq[k]);
    end
  endtask
  task automatic t_crc();
    frame(128'h010300100002, 6, 99, 16'h0001);
    dropped(3'h2);
  endtask
  // Each of the three line error flags alone spoils a frame.
  task automatic t_line();
    for (int i = 0; i < 3; i++) begin
      frame(128'h010300100002, 6, 99, 16'h0000, 3'h1 << i);
      dropped(3'h1);
    end
  endtask
  task automatic t_addr();
    frame(128'h020300100002, 6);
    dropped(3'h3);
  endtask
  task automatic t_gap();
    frame(128'h010300100002, 6, 3);
    dropped(3'h4);
  endtask
  // Byte count three against one word: length matches the count but not the quantity.
  task automatic t_len();
    frame(128'h01100001000103123456, 10);
    dropped(3'h5);
  endtask
  task automatic t_bread();
    frame(128'h000300100002, 6);
    dropped(3'h6);
  endtask
  task automatic t_bcast();
    frame(128'h001000010001021234, 9);
    chk("words", 16'h9, wq.size());
    chk("first", 16'h0200, wq[0]);
    chk("last", 16'h0334, wq[8]);
    chk("exc", 16'h0, n_exc);
  endtask
  task automatic t_exc();
    frame(128'h010500100002, 6);
    chk("exc_count", 16'h1, n_exc);
    chk("exc_code", 16'h1, exc_code);
    chk("exc_func", 16'h5, exc_func);
    chk("words", 16'h0, wq.size());
  endtask
  // Loopback passes, then a corrupted return latches the error.
  task automatic t_self();
    sel = SELF_TEST_SELECT;
    u_mbf_master_model.wait_ticks(150);
    chk("mode", 16'h1, self_test_mode);
    chk("pass", 16'h1, test_pass);
    chk("error", 16'h0, test_comm_error);
    flip = 8'h01;
    u_mbf_master_model.wait_ticks(60);
    chk("pass", 16'h0, test_pass);
    chk("error", 16'h1, test_comm_error);
    sel = 8'h00;
    flip = 8'h00;
    u_mbf_master_model.wait_ticks(60);
    chk("mode", 16'h0, self_test_mode);
    chk("error", 16'h0, test_comm_error);
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Every scenario starts and ends on a falling edge after a silent interval.
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    u_mbf_master_model.wait_ticks(45);
    t_good();
    t_crc();
    t_line();
    t_addr();
    t_gap();
    t_len();
    t_bread();
    t_bcast();
    t_exc();
    t_good();
    t_self();
    report_and_stop();
  end
endmodule
`default_nettype wire
